// [verilog/apc_pkg.sv]
// Package for the converter power and output-state sequencer
package apc_pkg;

  // System clock rate in MHz
  localparam int CLK_FREQ_MHZ   = 200;
  // Reference recharge time after sleep, in microseconds
  localparam int SLEEP_WAKE_US  = 1000;
  // Same time in system clock cycles (exact product, no rounding needed)
  localparam int SLEEP_WAKE_CYC = SLEEP_WAKE_US * CLK_FREQ_MHZ;
  // Recovery from nap, in sample clock cycles
  localparam int NAP_WAKE_CYC   = 100;
  // Width of one converted sample
  localparam int DATA_W         = 12;

  // One sample as it leaves on the output pins
  typedef struct packed {
    logic              overrange_flag; // Over or under range
    logic [DATA_W-1:0] data;           // Sample code
  } apc_sample_type;

  // Power state, one-hot
  typedef enum logic [4:0] {
    ST_SLEEP      = 5'h01,  // Everything off, reference too
    ST_NAP        = 5'h02,  // Reference on, conversion path off
    ST_SLEEP_WAKE = 5'h04,  // Reference recharging
    ST_NAP_WAKE   = 5'h08,  // Pipeline refilling
    ST_RUN        = 5'h10   // Normal conversion
  } apc_state_type;

  // Reset values
  localparam apc_state_type RST_STATE = ST_SLEEP;
  localparam logic          RST_COLD  = 1'b1;

endpackage

// [verilog/apc_power_output_control.sv]
// Power-down, nap and output high-impedance control of the converter
//
// Summary of operation
// - Output disable high tristates data, flag, clock
// - Power-down select low gives normal conversion
// - Both inputs high: sleep, reference off too
// - Samples invalid for milliseconds after sleep
// - Power-down high, disable low: nap, reference kept
// - Valid data about 100 sample clocks after nap; a nap entered from sleep waits out the sleep recovery
// - Sleep or nap keeps all outputs tristated
// - Bus A data changes on its clock rising
`timescale 1ns/1ps

module apc_power_output_control #(
  parameter int SLEEP_WAKE_CYCLES = apc_pkg::SLEEP_WAKE_CYC, // Reference recharge, clk cycles
  parameter int NAP_WAKE_CYCLES   = apc_pkg::NAP_WAKE_CYC    // Nap recovery, sample clocks
) (
  input  wire logic                    clk,               // System clock, 200 MHz
  input  wire logic                    resetn,            // Async reset, active low
  input  wire logic                    enc_clk,           // Sample (encode) clock
  input  wire logic                    power_down_select, // Pin, high requests power down
  input  wire logic                    output_disable,    // Pin, high tristates outputs
  input  wire apc_pkg::apc_sample_type core_sample,       // Converter core result, enc_clk
  output logic                         ref_power_on_q,    // Reference supply on
  output logic                         core_power_on_q,   // Conversion path supply on
  output apc_pkg::apc_state_type       power_state_q,     // Current power state
  output apc_pkg::apc_sample_type      pin_out_q,         // Data and overrange pins
  output logic                         bus_a_clock_out_q, // Bus A clock pin
  output logic                         pin_oe_q,          // Enable of every output pin
  output logic                         sample_valid_q     // Sample on pins is valid
);
  import apc_pkg::*;

  // Counter sizes
  localparam int SW_W = $clog2(SLEEP_WAKE_CYCLES + 1);
  localparam int NW_W = $clog2(NAP_WAKE_CYCLES + 1);
  // Last count values, at counter width
  localparam logic [SW_W-1:0] SW_LAST = SW_W'(SLEEP_WAKE_CYCLES - 1);
  localparam logic [NW_W-1:0] NW_LAST = NW_W'(NAP_WAKE_CYCLES - 1);
  // Plain copies for assertions
  localparam int SW_LAST_I = SLEEP_WAKE_CYCLES - 1;
  localparam int NW_LAST_I = NAP_WAKE_CYCLES - 1;

  // True in the two resting states
  function automatic logic is_rest(input apc_state_type st);
    is_rest = (st == ST_SLEEP) || (st == ST_NAP);
  endfunction

  // ---------------- System clock domain ----------------
  logic            pd_m_q;      // Power-down pin, first stage
  logic            pd_s_q;      // Power-down pin, synced
  logic            oed_m_q;     // Disable pin, first stage
  logic            oed_s_q;     // Disable pin, synced
  logic            done_m_q;    // Pipeline ready, first stage
  logic            done_s_q;    // Pipeline ready, synced
  logic            nw_done_q;   // Pipeline refilled, sample domain
  apc_state_type   st_q;        // Power state
  apc_state_type   st_d;
  logic [SW_W-1:0] wcnt_q;      // Reference recharge counter
  logic [SW_W-1:0] wcnt_d;
  logic            cold_q;      // Reference not yet settled
  logic            cold_d;
  logic            drive_q;     // Pins may be driven
  logic            drive_d;
  logic            run_q;       // Samples may be flagged valid
  logic            run_d;
  logic            ref_d;
  logic            core_d;

  // Pin and cross-domain synchronisers; first stages feed only second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pd_m_q   <= 1'b0;
      pd_s_q   <= 1'b0;
      oed_m_q  <= 1'b0;
      oed_s_q  <= 1'b0;
      done_m_q <= 1'b0;
      done_s_q <= 1'b0;
    end else begin
      pd_m_q   <= power_down_select;
      pd_s_q   <= pd_m_q;
      oed_m_q  <= output_disable;
      oed_s_q  <= oed_m_q;
      done_m_q <= nw_done_q;
      done_s_q <= done_m_q;
    end
  end

  // Power state decision
  always_comb begin
    st_d   = st_q;
    wcnt_d = '0;
    cold_d = cold_q;
    if (pd_s_q) begin
      st_d = oed_s_q ? ST_SLEEP : ST_NAP;
      // Sleep drops the reference, so its charge is lost
      if (oed_s_q) begin
        cold_d = 1'b1;
      end
    end else begin
      unique case (st_q)
        ST_SLEEP: begin
          // Wait until the sample side saw power drop
          if (!done_s_q) begin
            st_d = ST_SLEEP_WAKE;
          end
        end
        ST_NAP: begin
          // A nap entered from sleep still has a cold reference
          if (!done_s_q) begin
            st_d = cold_q ? ST_SLEEP_WAKE : ST_NAP_WAKE;
          end
        end
        ST_SLEEP_WAKE: begin
          if (wcnt_q == SW_LAST) begin
            wcnt_d = wcnt_q;
            if (done_s_q) begin
              st_d   = ST_RUN;
              cold_d = 1'b0;
            end
          end else begin
            wcnt_d = wcnt_q + 1'b1;
          end
        end
        ST_NAP_WAKE: begin
          if (done_s_q) begin
            st_d = ST_RUN;
          end
        end
        ST_RUN: begin
          // Stay converting
          st_d = ST_RUN;
        end
        default: begin
          // Illegal code: fall back to the safest state
          st_d = ST_SLEEP;
        end
      endcase
    end
    ref_d   = (st_d != ST_SLEEP);
    core_d  = !is_rest(st_d);
    drive_d = !oed_s_q && !is_rest(st_d);
    run_d   = (st_d == ST_RUN);
  end

  // Power state registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q            <= RST_STATE;
      wcnt_q          <= '0;
      cold_q          <= RST_COLD;
      drive_q         <= 1'b0;
      run_q           <= 1'b0;
      ref_power_on_q  <= 1'b0;
      core_power_on_q <= 1'b0;
    end else begin
      st_q            <= st_d;
      wcnt_q          <= wcnt_d;
      cold_q          <= cold_d;
      drive_q         <= drive_d;
      run_q           <= run_d;
      ref_power_on_q  <= ref_d;
      core_power_on_q <= core_d;
    end
  end

  // State output straight from its register
  assign power_state_q = st_q;

  // ---------------- Sample clock domain ----------------
  logic            core_m_q;    // Core power, first stage
  logic            core_s_q;    // Core power, synced
  logic            drv_m_q;     // Drive permit, first stage
  logic            drv_s_q;     // Drive permit, synced
  logic            run_m_q;     // Run flag, first stage
  logic            run_s_q;     // Run flag, synced
  logic [NW_W-1:0] nw_cnt_q;    // Pipeline refill counter
  logic [NW_W-1:0] nw_cnt_d;
  logic            nw_done_d;
  apc_sample_type  pin_out_d;
  logic            clk_out_d;
  logic            valid_d;

  // Synchronisers from the system domain
  always_ff @(posedge enc_clk or negedge resetn) begin
    if (!resetn) begin
      core_m_q <= 1'b0;
      core_s_q <= 1'b0;
      drv_m_q  <= 1'b0;
      drv_s_q  <= 1'b0;
      run_m_q  <= 1'b0;
      run_s_q  <= 1'b0;
    end else begin
      core_m_q <= core_power_on_q;
      core_s_q <= core_m_q;
      drv_m_q  <= drive_q;
      drv_s_q  <= drv_m_q;
      run_m_q  <= run_q;
      run_s_q  <= run_m_q;
    end
  end

  // Refill count, output clock and data update
  always_comb begin
    if (!core_s_q) begin
      nw_cnt_d = '0;
    end else if (nw_done_q) begin
      nw_cnt_d = nw_cnt_q;
    end else begin
      nw_cnt_d = nw_cnt_q + 1'b1;
    end
    nw_done_d = core_s_q && (nw_done_q || (nw_cnt_q == NW_LAST));
    clk_out_d = ~bus_a_clock_out_q;
    pin_out_d = pin_out_q;
    valid_d   = sample_valid_q;
    if (!bus_a_clock_out_q) begin
      pin_out_d = core_sample;
      valid_d   = run_s_q;
    end
  end

  // Sample domain registers; the enable lags the drive permit by three edges
  always_ff @(posedge enc_clk or negedge resetn) begin
    if (!resetn) begin
      nw_cnt_q          <= '0;
      nw_done_q         <= 1'b0;
      bus_a_clock_out_q <= 1'b0;
      pin_out_q         <= '0;
      sample_valid_q    <= 1'b0;
      pin_oe_q          <= 1'b0;
    end else begin
      nw_cnt_q          <= nw_cnt_d;
      nw_done_q         <= nw_done_d;
      bus_a_clock_out_q <= clk_out_d;
      pin_out_q         <= pin_out_d;
      sample_valid_q    <= valid_d;
      pin_oe_q          <= drv_s_q;
    end
  end

  // ---------------- Checks ----------------
  property p_dis_clk;
    @(posedge clk) disable iff (!resetn)
    oed_s_q |=> !drive_q;
  endproperty
  a_dis_clk: assert property (p_dis_clk) else $error("drive permit with disable high");

  property p_dis_pin;
    @(posedge enc_clk) disable iff (!resetn)
    !drv_s_q |=> !pin_oe_q;
  endproperty
  a_dis_pin: assert property (p_dis_pin) else $error("pins driven without permit");

  property p_run_hold;
    @(posedge clk) disable iff (!resetn)
    (!pd_s_q && st_q == ST_RUN) |=> (st_q == ST_RUN) && ref_power_on_q && core_power_on_q;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("left normal with select low");

  property p_sleep_in;
    @(posedge clk) disable iff (!resetn)
    (pd_s_q && oed_s_q) |=> (st_q == ST_SLEEP) && !ref_power_on_q && !core_power_on_q;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("sleep not entered");

  property p_sleep_out;
    @(posedge clk) disable iff (!resetn)
    (st_q == ST_RUN && $past(st_q) == ST_SLEEP_WAKE) |-> $past(wcnt_q) == SW_LAST_I;
  endproperty
  a_sleep_out: assert property (p_sleep_out) else $error("sleep recovery too short");

  property p_nap_in;
    @(posedge clk) disable iff (!resetn)
    (pd_s_q && !oed_s_q) |=> (st_q == ST_NAP) && ref_power_on_q && !core_power_on_q;
  endproperty
  a_nap_in: assert property (p_nap_in) else $error("nap not entered");

  property p_nap_out;
    @(posedge enc_clk) disable iff (!resetn)
    $rose(nw_done_q) |-> $past(nw_cnt_q) == NW_LAST_I && $past(core_s_q);
  endproperty
  a_nap_out: assert property (p_nap_out) else $error("nap recovery count wrong");

  property p_rest_hiz;
    @(posedge clk) disable iff (!resetn)
    is_rest(st_q) |-> !drive_q && !run_q;
  endproperty
  a_rest_hiz: assert property (p_rest_hiz) else $error("outputs live while resting");

  property p_data_edge;
    @(posedge enc_clk) disable iff (!resetn)
    $changed(pin_out_q) |-> $rose(bus_a_clock_out_q);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data moved off rising clock");

  property p_valid_run;
    @(posedge enc_clk) disable iff (!resetn)
    $rose(sample_valid_q) |-> $past(run_s_q) && $past(nw_done_q);
  endproperty
  a_valid_run: assert property (p_valid_run) else $error("valid before recovery");

  property p_cv_sleep;
    @(posedge clk) disable iff (!resetn)
    st_q == ST_RUN ##1 st_q == ST_SLEEP;
  endproperty
  c_cv_sleep: cover property (p_cv_sleep);

  property p_cv_nap;
    @(posedge clk) disable iff (!resetn)
    st_q == ST_RUN ##1 st_q == ST_NAP;
  endproperty
  c_cv_nap: cover property (p_cv_nap);

  property p_cv_nap_back;
    @(posedge clk) disable iff (!resetn)
    st_q == ST_NAP_WAKE ##1 st_q == ST_RUN;
  endproperty
  c_cv_nap_back: cover property (p_cv_nap_back);

  property p_cv_sleep_back;
    @(posedge clk) disable iff (!resetn)
    st_q == ST_SLEEP_WAKE ##1 st_q == ST_RUN;
  endproperty
  c_cv_sleep_back: cover property (p_cv_sleep_back);

endmodule

// [tb/apc_capture_model.sv]
// Capture-side model that latches bus A samples from the pins
`timescale 1ns/1ps

module apc_capture_model (
  input  wire logic                    resetn,       // Async reset, active low
  input  wire logic                    clk_wire,     // Bus A clock as seen on the board
  input  wire apc_pkg::apc_sample_type pin_wire,     // Data pins as seen on the board
  input  wire logic                    pin_oe,       // Pins driven by the converter
  input  wire logic                    sample_valid, // Pins hold good data
  output apc_pkg::apc_sample_type      cap_sample,   // Last latched sample
  output logic                         cap_use,      // Latched sample may be used
  output int                           cap_cnt       // Falling clock edges seen
);
  import apc_pkg::*;

  logic oe_at_rise; // Pins were driven when the sample launched

  // A sample launched while floating is stale, so remember the drive state
  always_ff @(posedge clk_wire or negedge resetn) begin
    if (!resetn) begin
      oe_at_rise <= 1'b0;
    end else begin
      oe_at_rise <= pin_oe;
    end
  end

  always_ff @(negedge clk_wire or negedge resetn) begin
    if (!resetn) begin
      cap_sample <= '0;
      cap_use    <= 1'b0;
      cap_cnt    <= 0;
    end else begin
      cap_sample <= pin_wire;
      cap_use    <= pin_oe && oe_at_rise && sample_valid;
      cap_cnt    <= cap_cnt + 1;
    end
  end
endmodule

// [tb/apc_power_output_control_bench.sv]
// Bench for the converter power and output-state sequencer
`timescale 1ns/1ps

module apc_power_output_control_bench;
  import apc_pkg::*;

  localparam int SW = 20; // Short reference recharge, clk cycles
  localparam int NW = 8;  // Nap recovery, sample clocks

  logic           clk = 1'b0;               // System clock
  logic           enc_clk = 1'b0;           // Sample clock
  logic           resetn;                   // Reset, active low, set at time 0
  logic           power_down_select = 1'b0; // Power-down pin
  logic           output_disable = 1'b0;    // Tristate pin
  apc_sample_type core_sample = '0;         // Core result
  logic           ref_on, core_on, co, oe, valid, clk_wire, cap_use;
  apc_state_type  state;                    // Power state seen
  apc_sample_type pins, pin_wire, cap_sample, exp_sample;
  apc_sample_type exp_q[$];                 // Samples launched, oldest first
  int             cap_cnt, n;
  int             miscompares = 0;
  int             num_checks = 0;

  // Main clock, 200 MHz
  always #2.5 clk = ~clk;
  // Sample clock, offset so edges never line up with clk
  initial begin
    #3.3;
    forever #16 enc_clk = ~enc_clk;
  end
  // Floating pins show a changing level, never the last value
  assign pin_wire = oe ? pins : ~pins;
  assign clk_wire = oe ? co : ~co;

  apc_power_output_control #(.SLEEP_WAKE_CYCLES(SW), .NAP_WAKE_CYCLES(NW))
    apc_power_output_control_inst (.clk(clk), .resetn(resetn), .enc_clk(enc_clk),
    .power_down_select(power_down_select), .output_disable(output_disable),
    .core_sample(core_sample), .ref_power_on_q(ref_on), .core_power_on_q(core_on),
    .power_state_q(state), .pin_out_q(pins), .bus_a_clock_out_q(co), .pin_oe_q(oe),
    .sample_valid_q(valid));

  apc_capture_model apc_capture_model_inst (.resetn(resetn), .clk_wire(clk_wire),
    .pin_wire(pin_wire), .pin_oe(oe), .sample_valid(valid), .cap_sample(cap_sample),
    .cap_use(cap_use), .cap_cnt(cap_cnt));

  // New random core result away from the capture edge
  always @(negedge enc_clk) begin
    core_sample <= apc_sample_type'((DATA_W + 1)'($urandom));
  end
  // Note each launched sample as the clock pin rises
  always @(posedge clk_wire) begin
    if (resetn) begin
      exp_q.push_back(core_sample);
    end
  end
  // Each capture takes the oldest note
  always @(cap_cnt) begin
    if (!resetn) begin
      exp_q.delete();
    end else if (exp_q.size() > 0) begin
      exp_sample = exp_q.pop_front();
      if (cap_use) begin
        chk_sample("pins", exp_sample, cap_sample);
      end
    end
  end

  task automatic chk_bit(string nm, logic e, logic g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk_state(apc_state_type e, apc_state_type g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED state expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_sample(string nm, apc_sample_type e, apc_sample_type g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_count(string nm, int g, int lo, int hi);
    num_checks++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Bounded wait: 0 valid high, 1 pins floating, 2 pins driven
  task automatic wait_for(int sel, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < 4000) begin
      @(negedge clk);
      cnt++;
      hit = (sel == 0) ? (valid === 1'b1) : (sel == 1) ? (oe === 1'b0) : (oe === 1'b1);
    end
    if (!hit) begin
      miscompares++;
      $display("CHECK FAILED wait %0d expected hit seen timeout", sel);
      end_of_test();
    end
  endtask

  task automatic set_pins(logic pd, logic od);
    @(posedge clk);
    power_down_select <= pd;
    output_disable    <= od;
  endtask

  // Rest state: pins floating, no valid data, core off
  task automatic check_rest(apc_state_type st, logic ref_exp);
    wait_for(1, n);
    repeat (40) @(negedge clk);
    chk_state(st, state);
    chk_bit("ref", ref_exp, ref_on);
    chk_bit("core", 1'b0, core_on);
    chk_bit("oe", 1'b0, oe);
    chk_bit("valid", 1'b0, valid);
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    // Step from unknown to low is an edge, so both domains reset at once
    resetn <= 1'b0;
    void'($urandom(64));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    // First wake after reset runs the cold reference path
    wait_for(0, n);
    chk_count("cold wake", n, SW, SW + 7 * NW + 100);
    chk_state(ST_RUN, state);
    chk_bit("ref", 1'b1, ref_on);
    chk_bit("core", 1'b1, core_on);
    chk_bit("oe", 1'b1, oe);
    repeat (300) @(posedge clk);
    // Nap and its short recovery
    set_pins(1'b1, 1'b0);
    check_rest(ST_NAP, 1'b1);
    set_pins(1'b0, 1'b0);
    wait_for(0, n);
    chk_count("nap wake", n, NW * 32 / 5, NW * 32 / 5 + 120);
    repeat (200) @(posedge clk);
    // Sleep, reference off, held 40 clk cycles after the pins float
    set_pins(1'b1, 1'b1);
    check_rest(ST_SLEEP, 1'b0);
    // Nap straight from sleep keeps the cold reference path
    set_pins(1'b1, 1'b0);
    check_rest(ST_NAP, 1'b1);
    set_pins(1'b0, 1'b1);
    repeat (5) @(negedge clk);
    chk_state(ST_SLEEP_WAKE, state);
    wait_for(0, n);
    chk_count("sleep wake", n, SW, SW + 7 * NW + 100);
    chk_state(ST_RUN, state);
    chk_bit("oe", 1'b0, oe);
    set_pins(1'b0, 1'b0);
    wait_for(2, n);
    chk_count("enable", n, 1, 40);
    repeat (300) @(posedge clk);
    end_of_test();
  end
endmodule
